// file: dv/gpm_misc_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module gpm_misc_ctrl_checker
  import gpm_pkg::*;
#(
  parameter int MUX_FUNCS = 4
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 ce,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [29:0]          pin_oe,
  input wire logic [29:0]          periph_oe,
  input wire logic [MUX_FUNCS-1:0] func_in,
  input wire logic                 temp_sensor_enable,
  input wire logic                 temp_route_ch14,
  input wire logic                 share_switch_one_enable,
  input wire logic                 share_switch_two_enable
);
  // ------------------------------------------------------------------
  // shadow of the takeover mask
  // ------------------------------------------------------------------
  logic [29:0] tk;
  logic [29:0] next_tk;

  always_comb begin
    next_tk = tk;
    if (ce && psel && penable && pready && pwrite &&
        paddr == OFS_TAKEOVER) begin
      next_tk = pwdata[29:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk <= 30'h0000_0000;
    end else begin
      tk <= next_tk;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable && !pready && ce;
  endsequence

  property p_ready_next;
    s_access |=> pready;
  endproperty
  property p_ready_pulse;
    pready && ce |=> !pready;
  endproperty
  property p_ready_phase;
    pready |-> psel && penable;
  endproperty
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  property p_switch_excl;
    !(share_switch_one_enable && share_switch_two_enable);
  endproperty
  property p_route;
    temp_route_ch14 == temp_sensor_enable;
  endproperty
  property p_mux_one;
    $onehot0(func_in);
  endproperty
  property p_reset_quiet;
    !$past(presetn) |-> !temp_sensor_enable && !share_switch_one_enable
                        && !share_switch_two_enable;
  endproperty
  // unowned bits must mirror the peripheral one cycle later
  property p_periph_follow;
    $past(presetn) && $past(ce) |->
      (pin_oe & ~$past(tk)) == ($past(periph_oe) & ~$past(tk));
  endproperty

  a_ready_next: assert property (p_ready_next)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  a_ready_phase: assert property (p_ready_phase)
    else $error("ready outside access phase");
  a_err_zero: assert property (p_err_zero)
    else $error("error without ready or with data");
  a_switch_excl: assert property (p_switch_excl)
    else $error("both share switches closed");
  a_route: assert property (p_route)
    else $error("sensor route differs from enable");
  a_mux_one: assert property (p_mux_one)
    else $error("shared pin seen by several functions");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("analog control active after reset");
  a_periph_follow: assert property (p_periph_follow)
    else $error("unowned pin not following peripheral");
endmodule : gpm_misc_ctrl_checker
`default_nettype wire

// file: dv/gpm_misc_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module gpm_misc_ctrl_tb_top;
  import gpm_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [29:0] pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in;
  logic [3:0]  func_out, func_oe, func_in;
  logic        shared_pin_in, shared_pin_out, shared_pin_oe, err;
  logic        brownout_detect, brownout_irq, temp_sensor_enable;
  logic        temp_route_ch14, pulse_source_output;
  logic        share_switch_one_enable, share_switch_two_enable;
  int          n_errors, total_checks;

  gpm_misc_ctrl dut_u (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .periph_out,
    .periph_oe, .periph_in, .func_out, .func_oe, .func_in, .shared_pin_in,
    .shared_pin_out, .shared_pin_oe, .brownout_detect, .brownout_irq,
    .temp_sensor_enable, .temp_route_ch14, .share_switch_one_enable,
    .share_switch_two_enable, .pulse_source_output
  );

  always #2.5 pclk = ~pclk;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // master never assumes a latency; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_vals;
    rd_chk(OFS_TAKEOVER, 32'h0000_0000);
    rd_chk(OFS_PKG, {30'h0, PKG_CODE_RST});
    rd_chk(OFS_TEMP_CTRL, 32'h0000_0000);
    rd_chk(OFS_SHARE, {8'h00, DUTY_RST, PRD_RST, 8'h00});
    rd_chk(OFS_TEMP_CAL, {20'h0, TEMP_CAL_RST});
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask : t_reset_vals

  task automatic t_gpio;
    logic [29:0] tk, dir, od, val, e_oe, e_out;
    tk = 30'h0000_FFFF;
    dir = 30'h0000_0F0F;
    od = 30'h0000_3333;
    val = 30'h0000_5555;
    @(posedge pclk);
    periph_oe  <= 30'h1555_5555;
    periph_out <= 30'h0F0F_0F0F;
    wt(2);
    chk({2'b0, pin_oe}, {2'b0, periph_oe});
    apb(1'b1, OFS_DIR, {2'b0, dir});
    apb(1'b1, OFS_OPEN, {2'b0, od});
    apb(1'b1, OFS_VALUE, {2'b0, val});
    apb(1'b1, OFS_TAKEOVER, {2'b0, tk});
    for (int i = 0; i < 2; i++) begin
      wt(1);
      e_oe = (tk & dir & ~(od & val)) | (~tk & periph_oe);
      e_out = (tk & ~od & val) | (~tk & periph_out);
      chk({2'b0, pin_oe}, {2'b0, e_oe});
      chk({2'b0, pin_out}, {2'b0, e_out});
      @(posedge pclk);
      periph_oe <= ~periph_oe;
      periph_out <= ~periph_out;
      wt(1);
    end
    apb(1'b1, OFS_TAKEOVER, 32'h0000_0000);
    wt(1);
    chk({2'b0, pin_oe}, {2'b0, periph_oe});
    chk({2'b0, pin_out}, {2'b0, periph_out});
  endtask : t_gpio

  task automatic t_readback;
    @(posedge pclk);
    pin_in <= 30'h2345_6789;
    wt(6);
    chk({2'b0, periph_in}, 32'h2345_6789);
    rd_chk(OFS_READBACK, 32'h2345_6789);
    apb(1'b1, OFS_READBACK, 32'hFFFF_FFFF);
    rd_chk(OFS_READBACK, 32'h2345_6789);
    // enable low must hold the synchronised level
    @(posedge pclk);
    ce     <= 1'b0;
    pin_in <= 30'h0000_0000;
    wt(6);
    chk({2'b0, periph_in}, 32'h2345_6789);
    @(posedge pclk);
    ce <= 1'b1;
    wt(6);
    chk({2'b0, periph_in}, 32'h0000_0000);
  endtask : t_readback

  task automatic t_brownout;
    apb(1'b1, OFS_BROWNOUT, 32'h0000_0002);
    @(posedge pclk);
    brownout_detect <= 1'b1;
    wt(6);
    chk({31'h0, brownout_irq}, 32'h0000_0001);
    rd_chk(OFS_BROWNOUT, 32'h0000_0003);
    @(posedge pclk);
    brownout_detect <= 1'b0;
    wt(6);
    apb(1'b1, OFS_BROWNOUT, 32'h0000_0003);
    wt(2);
    chk({31'h0, brownout_irq}, 32'h0000_0000);
    rd_chk(OFS_BROWNOUT, 32'h0000_0002);
  endtask : t_brownout

  task automatic t_temp_mux;
    apb(1'b1, OFS_TEMP_CTRL, 32'h0000_0001);
    wt(1);
    chk({30'h0, temp_sensor_enable, temp_route_ch14}, 32'h3);
    @(posedge pclk);
    func_out <= 4'hA;
    func_oe <= 4'h6;
    shared_pin_in <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_MUX, 32'(s));
      wt(6);
      chk({30'h0, shared_pin_out, shared_pin_oe},
          {30'h0, func_out[s], func_oe[s]});
      chk({28'h0, func_in}, 32'h1 << s);
    end
  endtask : t_temp_mux

  task automatic t_share;
    int hi;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_SHARE, 32'h0002_0300 | 32'(m));
      wt(4);
      chk({30'h0, share_switch_one_enable, share_switch_two_enable},
          {30'h0, m == 1, m == 3});
      hi = 0;
      repeat (8) begin
        wt(1);
        if (pulse_source_output === 1'b1) hi++;
      end
      // period 3 counts 0..3, duty 2: half of every 4 cycles
      chk(32'(hi), (m == 1) ? 32'h4 : 32'h0);
    end
    rd_chk(OFS_SHARE, 32'h0002_0303);
  endtask : t_share

  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, brownout_detect} = '0;
    {paddr, pwdata, pin_in, periph_out, periph_oe} = '0;
    {func_out, func_oe, shared_pin_in} = '0;
    ce = 1'b1;
    n_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_gpio();
    t_readback();
    t_brownout();
    t_temp_mux();
    t_share();
    stop_test();
  end

  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule : gpm_misc_ctrl_tb_top

bind gpm_misc_ctrl gpm_misc_ctrl_checker #(.MUX_FUNCS(MUX_FUNCS)) chk_u (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pin_oe, .periph_oe, .func_in,
  .temp_sensor_enable, .temp_route_ch14, .share_switch_one_enable,
  .share_switch_two_enable
);
`default_nettype wire

// file: hdl/gpm_misc_ctrl.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module gpm_misc_ctrl
  import gpm_pkg::*;
#(
  parameter logic [29:0] GPIO_CAPABLE = 30'h3FFF_FFFF,
  parameter int          MUX_FUNCS    = 4,
  parameter int          MUX_SEL_W    = 2
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // general-purpose pins
  input  wire logic [29:0]          pin_in,
  output var  logic [29:0]          pin_out,
  output var  logic [29:0]          pin_oe,
  // owning peripherals
  input  wire logic [29:0]          periph_out,
  input  wire logic [29:0]          periph_oe,
  output var  logic [29:0]          periph_in,
  // shared multiplexed pin
  input  wire logic [MUX_FUNCS-1:0] func_out,
  input  wire logic [MUX_FUNCS-1:0] func_oe,
  output var  logic [MUX_FUNCS-1:0] func_in,
  input  wire logic                 shared_pin_in,
  output var  logic                 shared_pin_out,
  output var  logic                 shared_pin_oe,
  // supervisory and analog controls
  input  wire logic                 brownout_detect,
  output var  logic                 brownout_irq,
  output var  logic                 temp_sensor_enable,
  output var  logic                 temp_route_ch14,
  output var  logic                 share_switch_one_enable,
  output var  logic                 share_switch_two_enable,
  output var  logic                 pulse_source_output
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  gpm_sync_if #(.W(SYNC_W)) sync_bus ();
  assign sync_bus.raw = {shared_pin_in, brownout_detect, pin_in};
  gpm_pin_sync #(.W(SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .s       (sync_bus.sync)
  );

  wire logic [29:0] pin_level    = sync_bus.level[29:0];
  wire logic        bo_level     = sync_bus.level[SYNC_BO];
  wire logic        shared_level = sync_bus.level[SYNC_SHARED];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [29:0]           takeover,   next_takeover;
  logic [29:0]           dir_out,    next_dir_out;
  logic [29:0]           open_drain, next_open_drain;
  logic [29:0]           value,      next_value;
  logic [1:0]            pkg_code,   next_pkg_code;
  logic                  bo_flag,    next_bo_flag;
  logic                  bo_irq_en,  next_bo_irq_en;
  logic                  temp_en,    next_temp_en;
  logic [TEMP_CAL_W-1:0] temp_cal,   next_temp_cal;
  logic [MUX_SEL_W-1:0]  mux_sel,    next_mux_sel;
  logic [1:0]            share_mode, next_share_mode;
  logic [1:0]            share_test, next_share_test;
  logic [7:0]            pwm_prd,    next_pwm_prd;
  logic [7:0]            pwm_duty,   next_pwm_duty;
  logic [31:0]           next_prdata;
  logic                  next_pready, next_pslverr;

  logic        access, wr, mapped;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // apb decode and register updates
  // ----------------------------------------------------------------
  // one wait state keeps prdata registered
  assign access = psel & penable;
  assign wr     = access & pready & pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_TAKEOVER:  rd_mux[29:0] = takeover;
      OFS_DIR:       rd_mux[29:0] = dir_out;
      OFS_OPEN:      rd_mux[29:0] = open_drain;
      OFS_VALUE:     rd_mux[29:0] = value;
      OFS_READBACK:  rd_mux[29:0] = pin_level;
      OFS_PKG:       rd_mux[1:0]  = pkg_code;
      OFS_BROWNOUT: begin
        rd_mux[BO_FLAG_BIT]   = bo_flag;
        rd_mux[BO_IRQ_EN_BIT] = bo_irq_en;
      end
      OFS_TEMP_CTRL: rd_mux[TEMP_EN_BIT] = temp_en;
      OFS_TEMP_CAL:  rd_mux[TEMP_CAL_W-1:0] = temp_cal;
      OFS_MUX:       rd_mux[MUX_SEL_W-1:0] = mux_sel;
      OFS_SHARE: begin
        rd_mux[SHARE_MODE_LO +: 2] = share_mode;
        rd_mux[SHARE_TEST_LO +: 2] = share_test;
        rd_mux[SHARE_PRD_LO +: 8]  = pwm_prd;
        rd_mux[SHARE_DUTY_LO +: 8] = pwm_duty;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_takeover   = takeover;
    next_dir_out    = dir_out;
    next_open_drain = open_drain;
    next_value      = value;
    next_pkg_code   = pkg_code;
    next_bo_irq_en  = bo_irq_en;
    next_temp_en    = temp_en;
    next_temp_cal   = temp_cal;
    next_mux_sel    = mux_sel;
    next_share_mode = share_mode;
    next_share_test = share_test;
    next_pwm_prd    = pwm_prd;
    next_pwm_duty   = pwm_duty;
    next_bo_flag    = bo_flag;
    next_prdata     = prdata;
    next_pready     = pready;
    next_pslverr    = pslverr;
    if (ce) begin
      next_pready  = access & ~pready;
      next_pslverr = access & ~pready & ~mapped;
      if (access & ~pready) begin
        next_prdata = pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr) begin
        unique case (paddr)
          OFS_TAKEOVER:
            // non-digital pins never leave their owner
            next_takeover = pwdata[29:0] & GPIO_CAPABLE;
          OFS_DIR:       next_dir_out    = pwdata[29:0];
          OFS_OPEN:      next_open_drain = pwdata[29:0];
          OFS_VALUE:     next_value      = pwdata[29:0];
          OFS_PKG:       next_pkg_code   = pwdata[1:0];
          OFS_BROWNOUT:  next_bo_irq_en  = pwdata[BO_IRQ_EN_BIT];
          OFS_TEMP_CTRL: next_temp_en    = pwdata[TEMP_EN_BIT];
          // writable by design; the factory count is then gone
          OFS_TEMP_CAL:  next_temp_cal   = pwdata[TEMP_CAL_W-1:0];
          OFS_MUX:       next_mux_sel    = pwdata[MUX_SEL_W-1:0];
          OFS_SHARE: begin
            next_share_mode = pwdata[SHARE_MODE_LO +: 2];
            next_share_test = pwdata[SHARE_TEST_LO +: 2];
            next_pwm_prd    = pwdata[SHARE_PRD_LO +: 8];
            next_pwm_duty   = pwdata[SHARE_DUTY_LO +: 8];
          end
          default: ;
        endcase
      end
      // write one clears; a brownout in the same cycle wins
      if (wr && paddr == OFS_BROWNOUT && pwdata[BO_FLAG_BIT]) begin
        next_bo_flag = 1'b0;
      end
      if (bo_level) begin
        next_bo_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      takeover   <= TAKEOVER_RST;
      dir_out    <= PIN_REG_RST;
      open_drain <= PIN_REG_RST;
      value      <= PIN_REG_RST;
      pkg_code   <= PKG_CODE_RST;
      bo_flag    <= 1'b0;
      bo_irq_en  <= 1'b0;
      temp_en    <= 1'b0;
      temp_cal   <= TEMP_CAL_RST;
      mux_sel    <= '0;
      share_mode <= SHARE_OFF_A;
      share_test <= 2'h0;
      pwm_prd    <= PRD_RST;
      pwm_duty   <= DUTY_RST;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      takeover   <= next_takeover;
      dir_out    <= next_dir_out;
      open_drain <= next_open_drain;
      value      <= next_value;
      pkg_code   <= next_pkg_code;
      bo_flag    <= next_bo_flag;
      bo_irq_en  <= next_bo_irq_en;
      temp_en    <= next_temp_en;
      temp_cal   <= next_temp_cal;
      mux_sel    <= next_mux_sel;
      share_mode <= next_share_mode;
      share_test <= next_share_test;
      pwm_prd    <= next_pwm_prd;
      pwm_duty   <= next_pwm_duty;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // pin ownership and drive
  // ----------------------------------------------------------------
  logic [29:0] cen_oe, cen_out;
  logic [29:0] next_pin_oe, next_pin_out, next_periph_in;

  always_comb begin
    // open drain only pulls low, releases for a one
    cen_oe  = dir_out & ~(open_drain & value);
    cen_out = value & ~open_drain;
    next_pin_oe    = pin_oe;
    next_pin_out   = pin_out;
    next_periph_in = periph_in;
    if (ce) begin
      // peripheral path carries its own local gpio control
      next_pin_oe    = (takeover & cen_oe)  | (~takeover & periph_oe);
      next_pin_out   = (takeover & cen_out) | (~takeover & periph_out);
      next_periph_in = pin_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe    <= 30'h0000_0000;
      pin_out   <= 30'h0000_0000;
      periph_in <= 30'h0000_0000;
    end else begin
      pin_oe    <= next_pin_oe;
      pin_out   <= next_pin_out;
      periph_in <= next_periph_in;
    end
  end

  // ----------------------------------------------------------------
  // shared pin function select
  // ----------------------------------------------------------------
  logic [MUX_FUNCS-1:0] next_func_in;
  logic                 next_shared_out, next_shared_oe;

  always_comb begin
    next_func_in    = func_in;
    next_shared_out = shared_pin_out;
    next_shared_oe  = shared_pin_oe;
    if (ce) begin
      next_func_in = '0;
      // a select past the last function leaves the pin released
      next_shared_out = 1'b0;
      next_shared_oe  = 1'b0;
      for (int f = 0; f < MUX_FUNCS; f++) begin
        if (mux_sel == f[MUX_SEL_W-1:0]) begin
          next_func_in[f] = shared_level;
          next_shared_out = func_out[f];
          next_shared_oe  = func_oe[f];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_in        <= '0;
      shared_pin_out <= 1'b0;
      shared_pin_oe  <= 1'b0;
    end else begin
      func_in        <= next_func_in;
      shared_pin_out <= next_shared_out;
      shared_pin_oe  <= next_shared_oe;
    end
  end

  // ----------------------------------------------------------------
  // share switches, pulse source, analog controls
  // ----------------------------------------------------------------
  logic [7:0] pwm_cnt, next_pwm_cnt;
  logic       next_pulse, next_sw1, next_sw2;
  logic       next_irq,   next_temp_out;

  always_comb begin
    next_pwm_cnt  = pwm_cnt;
    next_pulse    = pulse_source_output;
    next_sw1      = share_switch_one_enable;
    next_sw2      = share_switch_two_enable;
    next_irq      = brownout_irq;
    next_temp_out = temp_sensor_enable;
    if (ce) begin
      next_sw1 = (share_mode == SHARE_PULSE);
      next_sw2 = (share_mode == SHARE_ANALOG);
      if (share_mode == SHARE_PULSE) begin
        next_pwm_cnt = (pwm_cnt >= pwm_prd) ? 8'h00 : pwm_cnt + 8'h01;
        next_pulse   = (pwm_cnt < pwm_duty);
      end else begin
        // pulse source idles low in every other mode
        next_pwm_cnt = 8'h00;
        next_pulse   = 1'b0;
      end
      next_irq      = bo_flag & bo_irq_en;
      next_temp_out = temp_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt                 <= 8'h00;
      pulse_source_output     <= 1'b0;
      share_switch_one_enable <= 1'b0;
      share_switch_two_enable <= 1'b0;
      brownout_irq            <= 1'b0;
      temp_sensor_enable      <= 1'b0;
      temp_route_ch14         <= 1'b0;
    end else begin
      pwm_cnt                 <= next_pwm_cnt;
      pulse_source_output     <= next_pulse;
      share_switch_one_enable <= next_sw1;
      share_switch_two_enable <= next_sw2;
      brownout_irq            <= next_irq;
      temp_sensor_enable      <= next_temp_out;
      temp_route_ch14         <= next_temp_out;
    end
  end

endmodule : gpm_misc_ctrl
`default_nettype wire

// file: hdl/gpm_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gpm_pin_sync
  import gpm_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input wire logic   pclk,
  input wire logic   presetn,
  input wire logic   ce,
  gpm_sync_if.sync   s
);

  // ----------------------------------------------------------------
  // three-stage capture, accept a level once stages two and three agree
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [2:0] stage;
      logic [2:0] next_stage;
      logic       lvl;
      logic       next_lvl;
      always_comb begin
        next_stage = stage;
        next_lvl   = lvl;
        if (ce) begin
          next_stage = {stage[1:0], s.raw[i]};
          // stage[0] is read only by stage[1]
          if (stage[1] == stage[2]) begin
            next_lvl = stage[2];
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage <= 3'h0;
          lvl   <= 1'b0;
        end else begin
          stage <= next_stage;
          lvl   <= next_lvl;
        end
      end
      assign s.level[i] = lvl;
    end
  endgenerate

endmodule : gpm_pin_sync
`default_nettype wire

// file: hdl/gpm_pkg.sv
// Operation
// - takeover bit clear gives pin to its peripheral, set to central registers; reset zero
// - central registers choose input or output per pin
// - pin readback register returns the current level on each pin
// - a central output pin drives the value register bit
// - each pin output selectable open-drain or push-pull
// - only the 30 digital pins are ever usable as general-purpose pins
// - peripherals keep their own local pin control as the alternative path
// - a 2-bit package code field readable by firmware
// - brownout flag set on low supply; polled or raises an interrupt
// - temperature sensor disabled after reset, enabled only by firmware
// - temperature sensor output routed to converter channel 14
// - mux register connects exactly one function to the shared pin
// - share mode 00/10 off, 01 pulse bus switch one, 11 switch two
// - share register sets pulse period, duty and both share switches
package gpm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TAKEOVER  = 8'h00;
  localparam logic [7:0] OFS_DIR       = 8'h04;
  localparam logic [7:0] OFS_OPEN      = 8'h08;
  localparam logic [7:0] OFS_VALUE     = 8'h0C;
  localparam logic [7:0] OFS_READBACK  = 8'h10;
  localparam logic [7:0] OFS_PKG       = 8'h14;
  localparam logic [7:0] OFS_BROWNOUT  = 8'h18;
  localparam logic [7:0] OFS_TEMP_CTRL = 8'h1C;
  localparam logic [7:0] OFS_TEMP_CAL  = 8'h20;
  localparam logic [7:0] OFS_MUX       = 8'h24;
  localparam logic [7:0] OFS_SHARE     = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BO_FLAG_BIT   = 0;
  localparam int BO_IRQ_EN_BIT = 1;
  localparam int TEMP_EN_BIT   = 0;
  localparam int SHARE_MODE_LO = 0;
  localparam int SHARE_TEST_LO = 2;
  localparam int SHARE_PRD_LO  = 8;
  localparam int SHARE_DUTY_LO = 16;

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 30;
  localparam logic [29:0] TAKEOVER_RST = 30'h0000_0000;
  localparam logic [29:0] PIN_REG_RST  = 30'h0000_0000;
  // arbitrary neutral package code
  localparam logic [1:0]  PKG_CODE_RST = 2'h1;
  localparam int          TEMP_CAL_W   = 12;
  localparam logic [11:0] TEMP_CAL_RST = 12'h000;
  localparam logic [7:0]  PRD_RST      = 8'hFF;
  localparam logic [7:0]  DUTY_RST     = 8'h00;
  localparam int          TEMP_CHANNEL = 14;

  // sync vector layout: pins, then brownout, then shared pin
  localparam int SYNC_BO     = 30;
  localparam int SYNC_SHARED = 31;
  localparam int SYNC_W      = 32;

  typedef enum logic [1:0] {
    SHARE_OFF_A  = 2'h0,
    SHARE_PULSE  = 2'h1,
    SHARE_OFF_B  = 2'h2,
    SHARE_ANALOG = 2'h3
  } gpm_share_mode_t;

endpackage : gpm_pkg

// file: hdl/gpm_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gpm_sync_if #(parameter int W = 32);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport main (output raw, input level);
  modport sync (input raw, output level);
endinterface : gpm_sync_if
`default_nettype wire
